// *** src/dma_chan_pkg.sv ***
// Package of register offsets, descriptor fields, codes and timing for the DMA channel
package dma_chan_pkg;
    // ------------------------------------------------------------------
    // Register offsets (word addressed on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [2:0] OFF_DESCRIPTOR = 3'h0;
    localparam logic [2:0] OFF_COUNT      = 3'h1;
    localparam logic [2:0] OFF_SRC_LO     = 3'h2;
    localparam logic [2:0] OFF_SRC_HI     = 3'h3;
    localparam logic [2:0] OFF_DST_LO     = 3'h4;
    localparam logic [2:0] OFF_DST_HI     = 3'h5;
    localparam logic [2:0] OFF_CONTROL    = 3'h6;

    // ------------------------------------------------------------------
    // Descriptor field positions
    // ------------------------------------------------------------------
    localparam int POS_ENABLE   = 0;
    localparam int POS_SRC_STEP = 1;  // 3 bits
    localparam int POS_IRQ      = 4;
    localparam int POS_SIZE     = 5;  // 2 bits
    localparam int POS_HOLD     = 7;  // 2 bits
    localparam int POS_TYPE     = 9;  // 2 bits
    localparam int POS_DONE     = 11;
    localparam int POS_DST_STEP = 12; // 3 bits
    localparam int POS_STOP     = 15;

    localparam logic [15:0] DESC_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [23:0] ADDR_RESET  = 24'h000000;

    // Control register: bit0 stop input enable, bits 2:1 select, bit3 cache off
    localparam int POS_STOP_EN  = 0;
    localparam int POS_STOP_SEL = 1;
    localparam int POS_CACHE_OFF = 3;
    localparam int POS_WAITS    = 4;  // 4 bits of extra wait states

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [2:0] STEP_MEM_INC  = 3'h0;
    localparam logic [2:0] STEP_MEM_DEC  = 3'h1;
    localparam logic [2:0] STEP_MEM_HOLD = 3'h2;
    localparam logic [2:0] STEP_IO_INC   = 3'h4;
    localparam logic [2:0] STEP_IO_DEC   = 3'h5;
    localparam logic [2:0] STEP_IO_HOLD  = 3'h6;

    localparam logic [1:0] TYPE_FLOW     = 2'h0;
    localparam logic [1:0] TYPE_FLY_WR   = 2'h2;
    localparam logic [1:0] TYPE_FLY_RD   = 2'h3;

    localparam logic [1:0] HOLD_SINGLE   = 2'h0;
    localparam logic [1:0] HOLD_BURST    = 2'h1;
    localparam logic [1:0] HOLD_CONT     = 2'h2;

    localparam logic [1:0] SIZE_BYTE     = 2'h0;
    localparam logic [1:0] SIZE_WORD     = 2'h1;
    localparam logic [1:0] SIZE_LONG     = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS          = 40;
    localparam int RELEASE_CYCLES  = 16;
    localparam int RELEASE_NS      = RELEASE_CYCLES * CLK_NS;
    localparam int RELEASE_COUNT   = RELEASE_NS / CLK_NS;
endpackage : dma_chan_pkg

// *** src/dma_channel_descriptor_control.sv ***
// One DMA channel: descriptor, count, pointers and bus cycle sequencer
`timescale 1ns/1ps

module dma_channel_descriptor_control #(
    parameter bit FLYBY_CAPABLE = 1'b1
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        ready_in,
    input  wire logic        int_a_n,
    input  wire logic        int_b_n,
    input  wire logic [1:0]  channel_id,
    input  wire logic        bus_grant,
    input  wire logic        bus_ack,
    input  wire logic [31:0] bus_rdata,
    output logic             bus_req,
    output logic             bus_cycle,
    output logic             bus_write,
    output logic             bus_io,
    output logic      [23:0] bus_addr,
    output logic      [31:0] bus_wdata,
    output logic      [1:0]  bus_size,
    output logic             flyby_strobe,
    output logic             irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_REQ   = 6'b000010,
        ST_READ  = 6'b000100,
        ST_WRITE = 6'b001000,
        ST_FLY   = 6'b010000,
        ST_REL   = 6'b100000
    } phase_t;

    typedef struct packed {
        phase_t      phase;
        logic [15:0] desc;
        logic [15:0] count;
        logic [23:0] src;
        logic [23:0] dst;
        logic [7:0]  ctrl;
        logic [31:0] hold_data;
        logic [3:0]  waits;
        logic [4:0]  rel_cnt;
        logic [15:0] rdata;
        logic        req;
        logic        cyc;
        logic        wr;
        logic        io;
        logic [23:0] addr;
        logic [1:0]  size;
        logic        fly;
        logic        irq;
    } state_t;

    state_t st;
    state_t next_st;

    // Decoded descriptor fields
    logic        en;
    logic [2:0]  s_code;
    logic [2:0]  d_code;
    logic [1:0]  kind;
    logic [1:0]  policy;
    logic [1:0]  sz;
    logic        stop_hit;
    logic        size_ok;
    logic        type_ok;
    logic        want;
    logic [23:0] step;

    // ------------------------------------------------------------------
    // Field decode and legality
    // ------------------------------------------------------------------
    always_comb begin
        en     = st.desc[dma_chan_pkg::POS_ENABLE];
        s_code = st.desc[dma_chan_pkg::POS_SRC_STEP +: 3];
        d_code = st.desc[dma_chan_pkg::POS_DST_STEP +: 3];
        kind   = st.desc[dma_chan_pkg::POS_TYPE +: 2];
        policy = st.desc[dma_chan_pkg::POS_HOLD +: 2];
        sz     = st.desc[dma_chan_pkg::POS_SIZE +: 2];
        // Early stop only counts when routed to this channel
        stop_hit = st.ctrl[dma_chan_pkg::POS_STOP_EN] &&
                   (st.ctrl[dma_chan_pkg::POS_STOP_SEL +: 2] == channel_id) &&
                   (!int_a_n || !int_b_n);
        // Reserved type and flyby on a plain channel never start
        type_ok = (kind == dma_chan_pkg::TYPE_FLOW) ||
                  (FLYBY_CAPABLE && kind[1]);
        size_ok = (sz == dma_chan_pkg::SIZE_BYTE) ||
                  (sz == dma_chan_pkg::SIZE_WORD) ||
                  (sz == dma_chan_pkg::SIZE_LONG && kind[1] &&
                   st.ctrl[dma_chan_pkg::POS_CACHE_OFF]);
        // Ready is ignored once count is zero; reserved policy idles
        want = en && (st.count != dma_chan_pkg::COUNT_RESET) && ready_in &&
               type_ok && size_ok &&
               (policy != 2'h3);
        unique case (sz)
            dma_chan_pkg::SIZE_WORD: step = 24'h000002;
            dma_chan_pkg::SIZE_LONG: step = 24'h000004;
            default:                 step = 24'h000001;
        endcase
    end

    // Pointer stepping by code; I/O codes step by one, hold codes keep the pointer
    function automatic logic [23:0] stepped(input logic [23:0] a,
                                            input logic [2:0]  c,
                                            input logic [23:0] s);
        logic [23:0] d;
        d = c[2] ? 24'h000001 : s;
        unique case (c[1:0])
            2'h0:    stepped = a + d;
            2'h1:    stepped = a - d;
            default: stepped = a;
        endcase
    endfunction : stepped

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.fly   = 1'b0;
        next_st.rdata = 16'h0000;

        // Register reads: data appears the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                dma_chan_pkg::OFF_DESCRIPTOR: next_st.rdata = st.desc;
                dma_chan_pkg::OFF_COUNT:      next_st.rdata = st.count;
                dma_chan_pkg::OFF_SRC_LO:     next_st.rdata = st.src[15:0];
                dma_chan_pkg::OFF_SRC_HI:     next_st.rdata = {8'h00, st.src[23:16]};
                dma_chan_pkg::OFF_DST_LO:     next_st.rdata = st.dst[15:0];
                dma_chan_pkg::OFF_DST_HI:     next_st.rdata = {8'h00, st.dst[23:16]};
                dma_chan_pkg::OFF_CONTROL:    next_st.rdata = {8'h00, st.ctrl};
                default:                      next_st.rdata = 16'h0000;
            endcase
        end

        // Register writes; flags take the written value like every other descriptor bit
        if (reg_wr) begin
            unique case (reg_addr)
                dma_chan_pkg::OFF_DESCRIPTOR: next_st.desc = reg_wdata;
                dma_chan_pkg::OFF_COUNT:      next_st.count = reg_wdata;
                dma_chan_pkg::OFF_SRC_LO:     next_st.src[15:0] = reg_wdata;
                dma_chan_pkg::OFF_SRC_HI:     next_st.src[23:16] = reg_wdata[7:0];
                dma_chan_pkg::OFF_DST_LO:     next_st.dst[15:0] = reg_wdata;
                dma_chan_pkg::OFF_DST_HI:     next_st.dst[23:16] = reg_wdata[7:0];
                dma_chan_pkg::OFF_CONTROL:    next_st.ctrl = reg_wdata[7:0];
                default:                      next_st.ctrl = st.ctrl;
            endcase
        end

        // Bus sequencer
        unique case (st.phase)
            ST_IDLE: begin
                if (want) begin
                    next_st.req   = 1'b1;
                    next_st.phase = ST_REQ;
                end
            end
            ST_REQ: begin
                if (!en) begin
                    next_st.req   = 1'b0;
                    next_st.phase = ST_IDLE;
                end else if (bus_grant) begin
                    next_st.cyc   = 1'b1;
                    next_st.size  = sz;
                    next_st.waits = st.ctrl[dma_chan_pkg::POS_WAITS +: 4];
                    // Pointers go out untranslated
                    if (kind == dma_chan_pkg::TYPE_FLOW) begin
                        next_st.wr    = 1'b0;
                        next_st.io    = s_code[2];
                        next_st.addr  = st.src;
                        next_st.phase = ST_READ;
                    end else begin
                        next_st.wr    = (kind == dma_chan_pkg::TYPE_FLY_WR);
                        next_st.io    = 1'b0;
                        next_st.addr  = next_st.wr ? st.dst : st.src;
                        next_st.fly   = 1'b1;
                        next_st.phase = ST_FLY;
                    end
                end
            end
            ST_READ: begin
                if (st.waits != 4'h0) begin
                    next_st.waits = st.waits - 4'h1;
                end else if (stop_hit) begin
                    // Read under stop is dropped, nothing written
                    next_st.cyc   = 1'b0;
                    next_st.phase = ST_REL;
                end else if (bus_ack) begin
                    next_st.hold_data = bus_rdata;
                    next_st.wr    = 1'b1;
                    next_st.io    = d_code[2];
                    next_st.addr  = st.dst;
                    next_st.waits = st.ctrl[dma_chan_pkg::POS_WAITS +: 4];
                    next_st.phase = ST_WRITE;
                end
            end
            ST_WRITE, ST_FLY: begin
                if (st.waits != 4'h0) begin
                    next_st.waits = st.waits - 4'h1;
                end else if (bus_ack) begin
                    next_st.cyc   = 1'b0;
                    next_st.count = st.count - 16'h0001;
                    if (kind == dma_chan_pkg::TYPE_FLOW ||
                        kind == dma_chan_pkg::TYPE_FLY_RD) begin
                        next_st.src = stepped(st.src, s_code, step);
                    end
                    if (kind == dma_chan_pkg::TYPE_FLOW ||
                        kind == dma_chan_pkg::TYPE_FLY_WR) begin
                        next_st.dst = stepped(st.dst, d_code, step);
                    end
                    if (st.count == 16'h0001) begin
                        next_st.desc[dma_chan_pkg::POS_DONE] = 1'b1;
                        next_st.phase = ST_REL;
                    end else if (stop_hit ||
                                 policy == dma_chan_pkg::HOLD_SINGLE ||
                                 (policy == dma_chan_pkg::HOLD_BURST &&
                                  !ready_in)) begin
                        next_st.phase = ST_REL;
                    end else begin
                        next_st.phase = ST_REQ;
                    end
                end
            end
            ST_REL: begin
                // Bus dropped well inside the allowed window
                next_st.req     = 1'b0;
                next_st.rel_cnt = 5'h00;
                next_st.phase   = ST_IDLE;
            end
            default: next_st.phase = ST_IDLE;
        endcase

        // Early stop while active: flag set, enable cleared, wins over writes
        if (stop_hit && st.phase != ST_IDLE && en) begin
            next_st.desc[dma_chan_pkg::POS_STOP]   = 1'b1;
            next_st.desc[dma_chan_pkg::POS_ENABLE] = 1'b0;
        end

        // Interrupt follows flags when allowed
        next_st.irq = next_st.desc[dma_chan_pkg::POS_IRQ] &&
                      (next_st.desc[dma_chan_pkg::POS_DONE] ||
                       next_st.desc[dma_chan_pkg::POS_STOP]);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st       <= '0;
            st.phase <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata    = st.rdata;
    assign bus_req      = st.req;
    assign bus_cycle    = st.cyc;
    assign bus_write    = st.wr;
    assign bus_io       = st.io;
    assign bus_addr     = st.addr;
    assign bus_wdata    = st.hold_data;
    assign bus_size     = st.size;
    assign flyby_strobe = st.fly;
    assign irq          = st.irq;

endmodule : dma_channel_descriptor_control

// *** verif/dma_channel_descriptor_control_properties.sv ***
// Bus-side assertions for one DMA channel
`timescale 1ns/1ps
module dma_channel_descriptor_control_properties (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        ready_in,
    input wire logic        bus_req,
    input wire logic        bus_cycle,
    input wire logic        bus_write,
    input wire logic        bus_ack,
    input wire logic [23:0] bus_addr,
    input wire logic [31:0] bus_rdata,
    input wire logic [31:0] bus_wdata,
    input wire logic [1:0]  bus_size,
    input wire logic        flyby_strobe
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // Bus cycle checks
    // ------------------------------------------------------------------
    AST_STROBE_PULSE:
        assert property (flyby_strobe |=> !flyby_strobe)
        else $error("flyby strobe longer than one cycle");
    AST_STROBE_IN_CYCLE:
        assert property (flyby_strobe |-> bus_cycle)
        else $error("flyby strobe outside a bus cycle");
    AST_FIRST_READ:
        assert property ($rose(bus_cycle) && !flyby_strobe |-> !bus_write)
        else $error("flowthrough cycle did not start with a read");
    // Written data must be what the read phase just captured
    AST_WRITE_DATA:
        assert property ((bus_cycle && !bus_write && bus_ack) ##1
            (bus_cycle && bus_write) |-> bus_wdata == $past(bus_rdata))
        else $error("write data differs from read data");
    AST_CYCLE_HOLD:
        assert property (bus_cycle && !bus_ack |=>
            bus_cycle && $stable(bus_addr))
        else $error("address moved before acknowledge");
    AST_RELEASE:
        assert property ($fell(bus_cycle) |-> ##[0:16] (!bus_req || bus_cycle))
        else $error("bus held idle too long");
    AST_REQ_READY:
        assert property ($rose(bus_req) |-> $past(ready_in))
        else $error("request without ready");
    AST_SIZE_LEGAL:
        assert property (bus_cycle |-> bus_size != 2'h3)
        else $error("reserved size on the bus");
    cover property ($rose(flyby_strobe));
    cover property (bus_cycle && bus_write && bus_ack);
    cover property ($fell(bus_req));
endmodule : dma_channel_descriptor_control_properties

bind dma_channel_descriptor_control dma_channel_descriptor_control_properties
    chk (.sys_clk(sys_clk), .rstn(rstn), .ready_in(ready_in),
    .bus_req(bus_req), .bus_cycle(bus_cycle), .bus_write(bus_write),
    .bus_ack(bus_ack), .bus_addr(bus_addr), .bus_rdata(bus_rdata),
    .bus_wdata(bus_wdata), .bus_size(bus_size), .flyby_strobe(flyby_strobe));

// *** verif/dma_bus_partner.sv ***
// Behavioural system bus with arbiter and one memory for the channel; I/O cycles are answered like memory
`timescale 1ns/1ps
module dma_bus_partner (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  ack_delay,
    input  wire logic        bus_req,
    input  wire logic        bus_cycle,
    input  wire logic [23:0] bus_addr,
    output logic             bus_grant,
    output logic             bus_ack,
    output logic      [31:0] bus_rdata
);
    logic [3:0]  wait_cnt;
    logic [31:0] last_data;
    // ------------------------------------------------------------------
    // Arbitration and cycle completion
    // ------------------------------------------------------------------
    // Grant lags request by a cycle; slow replies hold ack back
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bus_grant <= 1'b0;
            wait_cnt  <= 4'h0;
            last_data <= 32'h00000000;
        end else begin
            bus_grant <= bus_req;
            wait_cnt  <= (bus_cycle && !bus_ack) ? wait_cnt + 4'h1 : 4'h0;
            last_data <= bus_rdata;
        end
    end
    // Memory answers with its address; idle data never repeats itself
    assign bus_ack   = bus_cycle && (wait_cnt >= ack_delay);
    assign bus_rdata = bus_ack ? {8'hA5, bus_addr} : ~last_data;
endmodule : dma_bus_partner

// *** verif/dma_channel_descriptor_control_tb.sv ***
// Self-checking bench for the DMA channel with a behavioural bus
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module dma_channel_descriptor_control_tb;
    localparam logic [23:0] SRC0 = 24'h121230; // Even for word rows
    localparam logic [23:0] DST0 = 24'h344560;
    logic        sys_clk, rstn, reg_wr, reg_rd, ready_in, int_a_n, int_b_n;
    logic        bus_grant, bus_ack, bus_req, bus_cycle, bus_write;
    logic        flyby_strobe, irq, req_q, bus_io;
    logic [2:0]  reg_addr;
    logic [1:0]  channel_id, bus_size, t;
    logic [3:0]  ack_delay;
    logic [15:0] reg_wdata, reg_rdata, v, lo, hi;
    logic [15:0] rows [5];
    logic [15:0] bad [5];
    logic [23:0] bus_addr, fly_addr, expect_ptr;
    logic [31:0] bus_rdata, bus_wdata;
    int          failures, n_compared, cycles, strobes, writes, reqs, rd_len;
    int          r, k, io_cyc;

    dma_channel_descriptor_control #(.FLYBY_CAPABLE(1'b1)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ready_in(ready_in), .int_a_n(int_a_n),
        .int_b_n(int_b_n), .channel_id(channel_id), .bus_grant(bus_grant),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_req(bus_req),
        .bus_cycle(bus_cycle), .bus_write(bus_write), .bus_io(bus_io),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_size(bus_size),
        .flyby_strobe(flyby_strobe), .irq(irq));
    dma_bus_partner far_side (
        .sys_clk(sys_clk), .rstn(rstn), .ack_delay(ack_delay),
        .bus_req(bus_req), .bus_cycle(bus_cycle), .bus_addr(bus_addr),
        .bus_grant(bus_grant), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] mk(logic [1:0] ty, logic [1:0] sz,
            logic [1:0] hold, logic [2:0] sc, logic [2:0] dc, logic ie);
        return {1'b0, dc, 1'b0, ty, hold, sz, ie, sc, 1'b1};
    endfunction : mk
    // Pointer after three transfers
    function automatic logic [23:0] stepped(logic [23:0] a, logic [2:0] c,
                                            logic [1:0] sz);
        logic [23:0] d;
        d = c[2] ? 24'h000001 : 24'h000001 << sz;
        case (c[1:0])
            2'h0: return a + d * 24'h000003;
            2'h1: return a - d * 24'h000003;
            default: return a;
        endcase
    endfunction : stepped
    task automatic wr(logic [2:0] a, logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(logic [2:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Disable first so the old descriptor never runs on the new count
    task automatic prog(logic [15:0] d, logic [15:0] n);
        wr(3'h0, 16'h0000);
        wr(3'h1, n);
        wr(3'h2, SRC0[15:0]);
        wr(3'h3, {8'h00, SRC0[23:16]});
        wr(3'h4, DST0[15:0]);
        wr(3'h5, {8'h00, DST0[23:16]});
        #1;
        strobes = 0;
        writes = 0;
        reqs = 0;
        rd_len = 0;
        io_cyc = 0;
        wr(3'h0, d);
    endtask : prog
    task finish_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Event counters and run limit
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        req_q <= bus_req;
        if (bus_req && !req_q) reqs <= reqs + 1;
        if (flyby_strobe && strobes == 0) fly_addr <= bus_addr;
        if (flyby_strobe) strobes <= strobes + 1;
        if (bus_cycle && bus_write && bus_ack) writes <= writes + 1;
        if (bus_cycle && !bus_write) rd_len <= rd_len + 1;
        if (bus_cycle && bus_io && bus_ack) io_cyc <= io_cyc + 1;
        if (cycles == 30000) begin
            failures++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {ready_in, int_a_n, int_b_n} = 3'b111;
        channel_id = 2'h1;
        ack_delay = 4'h0;
        rows = '{mk(2'h0, 2'h0, 2'h0, 3'h0, 3'h6, 1'b1),
                 mk(2'h0, 2'h1, 2'h1, 3'h1, 3'h0, 1'b1),
                 mk(2'h0, 2'h0, 2'h2, 3'h4, 3'h5, 1'b1),
                 mk(2'h2, 2'h2, 2'h0, 3'h6, 3'h0, 1'b1),
                 mk(2'h3, 2'h1, 2'h2, 3'h2, 3'h6, 1'b0)};
        bad = '{mk(2'h1, 2'h0, 2'h0, 3'h0, 3'h0, 1'b1),
                mk(2'h2, 2'h2, 2'h0, 3'h6, 3'h0, 1'b1),
                mk(2'h0, 2'h0, 2'h3, 3'h0, 3'h0, 1'b1),
                mk(2'h2, 2'h3, 2'h0, 3'h6, 3'h0, 1'b1),
                mk(2'h0, 2'h0, 2'h0, 3'h0, 3'h0, 1'b1) & 16'hFFFE};
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        wr(3'h7, 16'hFFFF); // Unmapped index must swallow this
        for (r = 0; r < 6; r++) begin
            rd(r[2:0], v);
            `CHK("reset value", 16'h0000, v)
        end
        rd(3'h7, v);
        `CHK("unmapped", 16'h0000, v)
        wr(3'h6, 16'h0008); // Cache off lets long flyby run
        for (r = 0; r < 5; r++) begin
            ack_delay <= r[3:0];
            t = rows[r][10:9];
            prog(rows[r], 16'h0003);
            v = 16'h0000;
            for (k = 0; k < 300 && v[11] !== 1'b1; k++) rd(3'h0, v);
            k = reqs;
            repeat (20) @(posedge sys_clk);
            `CHK("done flag", 1'b1, v[11])
            `CHK("no request at zero", k, reqs)
            rd(3'h1, v);
            `CHK("count", 16'h0000, v)
            rd(3'h2, lo);
            rd(3'h3, hi);
            expect_ptr = t == 2'h2 ? SRC0
                       : stepped(SRC0, rows[r][3:1], rows[r][6:5]);
            `CHK("source", expect_ptr, {hi[7:0], lo})
            rd(3'h4, lo);
            rd(3'h5, hi);
            expect_ptr = t == 2'h3 ? DST0
                       : stepped(DST0, rows[r][14:12], rows[r][6:5]);
            `CHK("dest", expect_ptr, {hi[7:0], lo})
            `CHK("strobes", t[1] ? 3 : 0, strobes)
            `CHK("writes", t == 2'h3 ? 0 : 3, writes)
            `CHK("io cycles", (t == 2'h0) ? 3 * (rows[r][3] + rows[r][14]) : 0, io_cyc)
            if (t[1]) `CHK("fly addr", t[0] ? SRC0 : DST0, fly_addr)
            `CHK("irq", rows[r][4], irq)
        end
        wr(3'h6, 16'h0000); // Cache on: long flyby refused too
        for (r = 0; r < 5; r++) begin
            prog(bad[r], 16'h0003);
            repeat (30) @(posedge sys_clk);
            rd(3'h1, v);
            `CHK("refused count", 16'h0003, v)
            `CHK("refused req", 0, reqs)
        end
        // Early stop on line A, channel 1 selected, three wait states
        ack_delay <= 4'h0;
        wr(3'h6, 16'h0033);
        prog(mk(2'h0, 2'h0, 2'h2, 3'h0, 3'h0, 1'b1), 16'h0005);
        for (k = 0; k < 200 && writes == 0; k++) @(posedge sys_clk);
        int_a_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        int_a_n <= 1'b1;
        rd(3'h0, v);
        `CHK("stop flag", 1'b1, v[15])
        `CHK("enable", 1'b0, v[0])
        `CHK("stop irq", 1'b1, irq)
        `CHK("released", 1'b0, bus_req)
        `CHK("waits", 1'b1, rd_len > 3)
        rd(3'h1, v);
        `CHK("count left", 1'b1, v != 16'h0000)
        finish_test();
    end
endmodule : dma_channel_descriptor_control_tb
